// File: logic/pin_mux_pkg.sv
// Behaviour
// - In slave FIFO mode port A bits 4 and 5 are inputs selecting the FIFO.
// - Port A bit 6 alternate: asserted packet-commit input commits gathered FIFO data.
// - Packet-commit active level is chosen by polarity bit 5.
// - Port A bit 7 is port bit, status flag output or chip-select input.
// - With chip-select in use, FIFO enables and strobes count only while selected.
// - Interface mode switches port B between port bits and low data byte.
// - Port C alternate-select bit n (0 to 6) picks port bit or waveform address bit n; bit 7 is always a port bit.
// - In port role a pin drives, floats or is read as a port bit.
// - In slave FIFO mode port A bit 2 is output enable, polarity bit 4.
package pin_mux_pkg;

   // ----------------------------------------------------------------
   // Interface mode field encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] IF_MODE_PORTS = 2'h0;
   localparam logic [1:0] IF_MODE_WAVEFORM = 2'h2;
   localparam logic [1:0] IF_MODE_SLAVE_FIFO = 2'h3;
   localparam logic [1:0] IF_MODE_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POL_OE_BIT = 4;
   localparam int POL_COMMIT_BIT = 5;
   localparam int ALT_A_BIT7 = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ALT_RESET = 8'h00;
   localparam logic [7:0] POL_RESET = 8'h00;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam int SYNC_STAGES = 2;

endpackage

// File: logic/pin_sync_if.sv
`timescale 1ns/10ps
// Raw pin levels in, synchronised levels out.
interface pin_sync_if;
   logic [7:0] pa_raw;
   logic [7:0] pb_raw;
   logic [7:0] pc_raw;
   logic [7:0] pa_sync;
   logic [7:0] pb_sync;
   logic [7:0] pc_sync;
   modport sync (input pa_raw, input pb_raw, input pc_raw,
                 output pa_sync, output pb_sync, output pc_sync);
   modport user (output pa_raw, output pb_raw, output pc_raw,
                 input pa_sync, input pb_sync, input pc_sync);
endinterface

// File: logic/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   pin_sync_if.sync pins
);
   logic [23:0] stage1_r;
   logic [23:0] stage2_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage1_r <= 24'h000000;
         stage2_r <= 24'h000000;
      end else begin
         stage1_r <= {pins.pc_raw, pins.pb_raw, pins.pa_raw};
         stage2_r <= stage1_r;
      end
   end

   assign pins.pa_sync = stage2_r[7:0];
   assign pins.pb_sync = stage2_r[15:8];
   assign pins.pc_sync = stage2_r[23:16];
endmodule

// File: logic/fifo_port_pin_mux.sv
`timescale 1ns/10ps
module fifo_port_pin_mux (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] interface_config,
   input wire logic [7:0] port_a_alt_select,
   input wire logic [7:0] port_c_alt_select,
   input wire logic [7:0] fifo_pin_polarity,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_dir,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_dir,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_dir,
   input wire logic fourth_status_flag,
   input wire logic [7:0] fifo_data_out,
   input wire logic fifo_data_drive,
   input wire logic [6:0] waveform_addr_out,
   input wire logic [7:0] pa_pin_in,
   input wire logic [7:0] pb_pin_in,
   input wire logic [7:0] pc_pin_in,
   output logic [7:0] pa_pin_out,
   output logic [7:0] pa_pin_oe,
   output logic [7:0] pb_pin_out,
   output logic [7:0] pb_pin_oe,
   output logic [7:0] pc_pin_out,
   output logic [7:0] pc_pin_oe,
   output logic [7:0] port_a_in,
   output logic [7:0] port_b_in,
   output logic [7:0] port_c_in,
   output logic [7:0] interface_data_bus,
   output logic fifo_select_in0,
   output logic fifo_select_in1,
   output logic packet_commit_in,
   output logic slave_output_enable,
   output logic slave_chip_select_n,
   output logic fifo_strobes_allowed
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pin_sync_if sif ();
   assign sif.pa_raw = pa_pin_in;
   assign sif.pb_raw = pb_pin_in;
   assign sif.pc_raw = pc_pin_in;

   pin_sync u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pins(sif.sync)
   );

   // ----------------------------------------------------------------
   // Role decode
   // ----------------------------------------------------------------
   function automatic logic fifo_mode(input logic [1:0] m);
      return m == pin_mux_pkg::IF_MODE_SLAVE_FIFO;
   endfunction

   // Only the waveform and slave FIFO codes hand port B to the data bus.
   function automatic logic bus_mode(input logic [1:0] m);
      return (m == pin_mux_pkg::IF_MODE_WAVEFORM) || (m == pin_mux_pkg::IF_MODE_SLAVE_FIFO);
   endfunction

   logic slave_m;
   logic data_m;
   logic cs_m;
   logic flag_m;
   assign slave_m = fifo_mode(interface_config);
   assign data_m = bus_mode(interface_config);
   assign cs_m = slave_m && port_a_alt_select[pin_mux_pkg::ALT_A_BIT7];
   assign flag_m = data_m && !cs_m;

   logic cs_active;
   assign cs_active = !sif.pa_sync[7];

   // ----------------------------------------------------------------
   // Port A drive
   // ----------------------------------------------------------------
   logic [7:0] pa_out_nxt;
   logic [7:0] pa_oe_nxt;
   always_comb begin
      pa_out_nxt = port_a_out;
      pa_oe_nxt = port_a_dir;
      if (slave_m) begin
         pa_oe_nxt[2] = 1'b0;
         pa_oe_nxt[5:4] = 2'b00;
         pa_oe_nxt[6] = 1'b0;
      end
      if (cs_m) begin
         pa_oe_nxt[7] = 1'b0;
      end else if (flag_m) begin
         pa_out_nxt[7] = fourth_status_flag;
         pa_oe_nxt[7] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Port B and port C drive
   // ----------------------------------------------------------------
   logic [7:0] pb_out_nxt;
   logic [7:0] pb_oe_nxt;
   assign pb_out_nxt = data_m ? fifo_data_out : port_b_out;
   assign pb_oe_nxt = data_m ? {8{fifo_data_drive}} : port_b_dir;

   logic [7:0] pc_out_nxt;
   logic [7:0] pc_oe_nxt;
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_pc
         assign pc_out_nxt[gi] = port_c_alt_select[gi] ? waveform_addr_out[gi] : port_c_out[gi];
         assign pc_oe_nxt[gi] = port_c_alt_select[gi] | port_c_dir[gi];
      end
   endgenerate
   assign pc_out_nxt[7] = port_c_out[7];
   assign pc_oe_nxt[7] = port_c_dir[7];

   // ----------------------------------------------------------------
   // Pin output registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pa_pin_out <= pin_mux_pkg::PORT_RESET;
         pa_pin_oe <= pin_mux_pkg::PORT_RESET;
         pb_pin_out <= pin_mux_pkg::PORT_RESET;
         pb_pin_oe <= pin_mux_pkg::PORT_RESET;
         pc_pin_out <= pin_mux_pkg::PORT_RESET;
         pc_pin_oe <= pin_mux_pkg::PORT_RESET;
      end else begin
         pa_pin_out <= pa_out_nxt;
         pa_pin_oe <= pa_oe_nxt;
         pb_pin_out <= pb_out_nxt;
         pb_pin_oe <= pb_oe_nxt;
         pc_pin_out <= pc_out_nxt;
         pc_pin_oe <= pc_oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Readback and alternate inputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         port_a_in <= pin_mux_pkg::PORT_RESET;
         port_b_in <= pin_mux_pkg::PORT_RESET;
         port_c_in <= pin_mux_pkg::PORT_RESET;
         interface_data_bus <= pin_mux_pkg::PORT_RESET;
      end else begin
         port_a_in <= sif.pa_sync;
         port_b_in <= sif.pb_sync;
         port_c_in <= sif.pc_sync;
         interface_data_bus <= data_m ? sif.pb_sync : pin_mux_pkg::PORT_RESET;
      end
   end

   logic gate_ok;
   assign gate_ok = slave_m && (!cs_m || cs_active);

   // ----------------------------------------------------------------
   // FIFO address selects
   // ----------------------------------------------------------------
   // The selects are addresses, not strobes, so chip-select does not gate them.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fifo_select_in0 <= 1'b0;
         fifo_select_in1 <= 1'b0;
      end else begin
         fifo_select_in0 <= slave_m && sif.pa_sync[4];
         fifo_select_in1 <= slave_m && sif.pa_sync[5];
      end
   end

   // ----------------------------------------------------------------
   // Packet commit
   // ----------------------------------------------------------------
   // An idle pin at the inactive level must never read as a commit.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         packet_commit_in <= 1'b0;
      end else begin
         packet_commit_in <= gate_ok &&
            (sif.pa_sync[6] == fifo_pin_polarity[pin_mux_pkg::POL_COMMIT_BIT]);
      end
   end

   // ----------------------------------------------------------------
   // Slave output enable
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         slave_output_enable <= 1'b0;
      end else begin
         slave_output_enable <= gate_ok &&
            (sif.pa_sync[2] == fifo_pin_polarity[pin_mux_pkg::POL_OE_BIT]);
      end
   end

   // ----------------------------------------------------------------
   // Chip-select and strobe gate
   // ----------------------------------------------------------------
   // Both outputs use the same synchronised sample, so with chip-select in use they never disagree.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         slave_chip_select_n <= 1'b1;
         fifo_strobes_allowed <= 1'b0;
      end else begin
         slave_chip_select_n <= cs_m ? sif.pa_sync[7] : 1'b1;
         fifo_strobes_allowed <= gate_ok;
      end
   end

endmodule

// File: verif/fifo_port_pin_mux_sva.sv
`timescale 1ns/10ps
module fifo_port_pin_mux_sva (
   input wire logic sys_clk, rst_n, fifo_data_drive, fourth_status_flag, packet_commit_in,
   input wire logic slave_chip_select_n, fifo_strobes_allowed,
   input wire logic [1:0] interface_config,
   input wire logic [6:0] waveform_addr_out,
   input wire logic [7:0] port_a_alt_select, port_c_alt_select, fifo_pin_polarity, port_b_dir,
   input wire logic [7:0] fifo_data_out, pa_pin_in, pb_pin_in, pa_pin_out, pa_pin_oe,
   input wire logic [7:0] pb_pin_out, pb_pin_oe, pc_pin_out, pc_pin_oe, interface_data_bus
);
   // ----------------------------------------------------------------
   // Pin role checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire slv = (interface_config == 2'h3);
   wire [6:0] alt_c = port_c_alt_select[6:0];
   sequence s_commit_held;
      (slv && !port_a_alt_select[7] && $stable(fifo_pin_polarity) &&
       pa_pin_in[6] == fifo_pin_polarity[5])[*4];
   endsequence
   sequence s_bus_held;
      (interface_config[1] && $stable(interface_config) && $stable(pb_pin_in))[*4];
   endsequence
   a_reset_all_input: assert property ($rose(rst_n) |->
      {pa_pin_oe, pb_pin_oe, pc_pin_oe} == 24'h0 && slave_chip_select_n) else $error("reset drive");
   a_slave_pins_input: assert property (slv |=> pa_pin_oe[6:4] == 3'h0 && !pa_pin_oe[2])
      else $error("slave input driven");
   a_commit_level: assert property (s_commit_held |-> packet_commit_in)
      else $error("commit missing");
   a_flag_role: assert property (slv && !port_a_alt_select[7] |=> pa_pin_oe[7] &&
      pa_pin_out[7] == $past(fourth_status_flag)) else $error("flag pin");
   a_select_gate: assert property (slv && port_a_alt_select[7] && $stable(port_a_alt_select) &&
      $stable(interface_config) && slave_chip_select_n |-> !fifo_strobes_allowed && !packet_commit_in)
      else $error("gate open");
   a_bus_drive: assert property (interface_config[1] && fifo_data_drive |=>
      pb_pin_oe == 8'hff && pb_pin_out == $past(fifo_data_out)) else $error("bus drive");
   a_bus_capture: assert property (s_bus_held |-> interface_data_bus == pb_pin_in)
      else $error("bus capture");
   a_pc_addr_drive: assert property (alt_c != 7'h00 |=>
      (pc_pin_oe[6:0] & $past(alt_c)) == $past(alt_c) &&
      ((pc_pin_out[6:0] ^ $past(waveform_addr_out)) & $past(alt_c)) == 7'h00) else $error("pc addr");
   a_port_b_role: assert property (!interface_config[1] |=> pb_pin_oe == $past(port_b_dir))
      else $error("port b dir");
endmodule
bind fifo_port_pin_mux fifo_port_pin_mux_sva chk (.*);

// File: verif/fifo_master_model.sv
`timescale 1ns/10ps
module fifo_master_model (
   input wire logic sys_clk,
   input wire logic [7:0] pa_drv, pa_en, pb_drv, pb_en,
   input wire logic [7:0] pa_pin_out, pa_pin_oe, pb_pin_out, pb_pin_oe,
   output logic [7:0] pa_pin_in, pb_pin_in
);
   // ----------------------------------------------------------------
   // Wire levels
   // ----------------------------------------------------------------
   logic [7:0] float_r = 8'h5a;
   // Released lines show a pattern that flips every cycle.
   always_ff @(posedge sys_clk) begin
      float_r <= ~float_r;
   end
   assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & ((pa_en & pa_drv) | (~pa_en & float_r)));
   assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & ((pb_en & pb_drv) | (~pb_en & float_r)));
endmodule

// File: verif/tb_fifo_port_pin_mux.sv
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
module tb_fifo_port_pin_mux;
   logic sys_clk = 1'b0, rst_n = 1'b0, fourth_status_flag = 1'b0, fifo_data_drive = 1'b0;
   logic [1:0] interface_config = 2'h0;
   logic [6:0] waveform_addr_out = 7'h00;
   logic [7:0] port_a_alt_select = 8'h00, port_c_alt_select = 8'h00, fifo_pin_polarity = 8'h00;
   logic [7:0] port_a_out = 8'h00, port_a_dir = 8'h00, port_b_out = 8'h00, port_b_dir = 8'h00;
   logic [7:0] port_c_out = 8'h00, port_c_dir = 8'h00, fifo_data_out = 8'h00, pc_ext = 8'h33;
   logic [7:0] pa_drv = 8'h00, pa_en = 8'h00, pb_drv = 8'h00, pb_en = 8'h00;
   logic [7:0] pa_pin_in, pb_pin_in, pc_pin_in, pa_pin_out, pa_pin_oe, pb_pin_out, pb_pin_oe;
   logic [7:0] pc_pin_out, pc_pin_oe, port_a_in, port_b_in, port_c_in, interface_data_bus;
   logic fifo_select_in0, fifo_select_in1, packet_commit_in, slave_output_enable;
   logic slave_chip_select_n, fifo_strobes_allowed;
   int error_cnt = 0, n_checks = 0;
   fifo_port_pin_mux DUT (.*);
   fifo_master_model master (.*);
   assign pc_pin_in = (pc_pin_oe & pc_pin_out) | (~pc_pin_oe & pc_ext);
   initial forever #5 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Pin outputs trail their cause by one edge, readback of a pin the block drives by four.
   task automatic settle;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_ports;
      @(posedge sys_clk);
      port_b_dir <= 8'hf0;
      port_b_out <= 8'ha5;
      pb_en <= 8'h0f;
      pb_drv <= 8'h03;
      settle;
      `CHK("pb_oe", 8'hf0, pb_pin_oe);
      `CHK("pb_out", 8'ha0, pb_pin_out & 8'hf0);
      `CHK("pb_in", 8'ha3, port_b_in);
   endtask
   task automatic t_waveform;
      @(posedge sys_clk);
      port_c_alt_select <= 8'h55;
      waveform_addr_out <= 7'h3c;
      port_c_dir <= 8'h80;
      port_c_out <= 8'h80;
      settle;
      `CHK("pc_oe", 8'hd5, pc_pin_oe);
      `CHK("pc_out", 8'h94, pc_pin_out & 8'hd5);
      `CHK("pc_in", 8'hb6, port_c_in);
   endtask
   task automatic t_data_bus;
      @(posedge sys_clk);
      interface_config <= 2'h2;
      fifo_data_drive <= 1'b1;
      fifo_data_out <= 8'h96;
      settle;
      `CHK("bus_oe", 8'hff, pb_pin_oe);
      `CHK("bus_out", 8'h96, pb_pin_out);
      @(posedge sys_clk);
      fifo_data_drive <= 1'b0;
      pb_en <= 8'hff;
      pb_drv <= 8'h3c;
      settle;
      `CHK("bus_oe", 8'h00, pb_pin_oe);
      `CHK("bus_in", 8'h3c, interface_data_bus);
   endtask
   task automatic t_slave;
      @(posedge sys_clk);
      interface_config <= 2'h3;
      port_a_dir <= 8'h74;
      fourth_status_flag <= 1'b1;
      pa_en <= 8'h74;
      for (int i = 0; i < 8; i++) begin
         if (i > 0) @(posedge sys_clk);
         fifo_pin_polarity <= {2'h0, i[2], i[2], 4'h0};
         pa_drv <= {1'b0, i[0], i[1], i[0], 1'b0, i[1], 2'h0};
         settle;
         `CHK("sel", i[1:0], {fifo_select_in1, fifo_select_in0});
         `CHK("commit", i[0] == i[2], packet_commit_in);
         `CHK("soe", i[1] == i[2], slave_output_enable);
      end
      `CHK("pa_oe", 8'h80, pa_pin_oe);
      `CHK("flag", 1'b1, pa_pin_out[7]);
      `CHK("pa_in", 8'hf4, port_a_in & 8'hf4);
   endtask
   task automatic t_chip_select;
      @(posedge sys_clk);
      port_a_alt_select <= 8'h80;
      fifo_pin_polarity <= 8'h20;
      pa_en <= 8'hf4;
      pa_drv <= 8'hc0;
      settle;
      `CHK("pa7_oe", 1'b0, pa_pin_oe[7]);
      `CHK("gate", 8'h01, {fifo_strobes_allowed, packet_commit_in, slave_chip_select_n});
      @(posedge sys_clk);
      pa_drv <= 8'h40;
      settle;
      `CHK("gate", 8'h06, {fifo_strobes_allowed, packet_commit_in, slave_chip_select_n});
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle;
      `CHK("oe_all", 8'h00, pa_pin_oe | pb_pin_oe | pc_pin_oe);
      t_ports;
      t_waveform;
      t_data_bus;
      t_slave;
      t_chip_select;
      end_of_test;
   end
endmodule
